//--- verilog/rcrb_defs.vh
// register offsets, field positions, reset values, commands and timing of the config bank
`ifndef RCRB_DEFS_VH
`define RCRB_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RCRB_OFS_CONFIG 5'h00
`define RCRB_OFS_AUTO_ACK 5'h01
`define RCRB_OFS_RX_PIPES 5'h02
`define RCRB_OFS_ADDR_WIDTH 5'h03
`define RCRB_OFS_RETRANSMIT 5'h04
`define RCRB_OFS_STATUS 5'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCRB_BIT_MASK_RX 6
`define RCRB_BIT_MASK_TX 5
`define RCRB_BIT_MASK_RETRY 4
`define RCRB_BIT_CRC_EN 3
`define RCRB_BIT_CRC_LEN 2
`define RCRB_BIT_PWR 1
`define RCRB_BIT_PRIMARY_RECEIVER_SELECT 0
`define RCRB_BIT_RX_READY 6
`define RCRB_BIT_TX_DONE 5
`define RCRB_BIT_RETRY_LIMIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RCRB_RST_CONFIG 7'h08
`define RCRB_RST_AUTO_ACK 6'h3F
`define RCRB_RST_RX_PIPES 6'h03
`define RCRB_RST_ADDR_WIDTH 2'h3
`define RCRB_RST_RETR_DELAY 4'h0
`define RCRB_RST_RETR_COUNT 4'h3

// ----------------------------------------------------------------
// spi commands
// ----------------------------------------------------------------
`define RCRB_CMD_READ 3'h0
`define RCRB_CMD_WRITE 3'h1
`define RCRB_CMD_NOP 8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCRB_CLK_PERIOD_NS 5
`define RCRB_RETR_STEP_US 250
`define RCRB_RETR_STEP_CYCLES (`RCRB_RETR_STEP_US * 1000 / `RCRB_CLK_PERIOD_NS)

`endif

//--- verilog/rcrb_radio_config_register_bank.v
// spi-accessed configuration register bank, offsets 0x00 to 0x04 plus event flags
`timescale 1ns/1ps
`include "rcrb_defs.vh"

// Contract
// R1: undefined bit positions of every register read back as zero.
// R2: bit 6 set keeps receive-ready flag off the interrupt pin; reset 0.
// R3: bit 5 set keeps transmit-done flag off the interrupt pin; reset 0.
// R4: bit 4 set keeps retry-limit flag off the interrupt pin; reset 0.
// R5: crc enable resets 1, reads and acts 1 when any auto-ack bit set.
// R6: bit 2 picks crc length: 0 one byte, 1 two bytes; reset 0.
// R7: bit 1 powers up when 1, power down when 0; reset 0.
// R8: bit 0 selects primary receiver when 1, transmitter when 0; reset 0.
// R9: register 0x01 bits 5:0 enable auto-ack per pipe; all reset to 1.
// R10: host should clear auto-ack enables to talk to older transceivers.
// R11: register 0x02 bits 5:0 enable pipes; pipes 0,1 on, others off at reset.
// R12: address width code 01=3, 10=4, 11=5 bytes; reset 11; 00 illegal.
// R13: shorter address widths use only the least significant address bytes.
// R14: register 0x04 upper nibble sets retransmit delay; code 0 waits 250 us.
// R15: host writes zero to every reserved bit.
// R16: each delay code step adds 250 us, up to 4000 us at code 15.
// R17: interrupt pin low while any unmasked flag set; writing 1 clears flag.
// R18: host writes configuration only in standby or power down.
// R19: all fields take their reset values at power-on before any access.
module rcrb_radio_config_register_bank #(
    parameter RETR_STEP_CYCLES = `RCRB_RETR_STEP_CYCLES
) (
    input wire clk, // 200 MHz system clock
    input wire nrst, // async reset, active low
    input wire spi_csn_n, // spi chip select from host, active low
    input wire spi_sck, // spi clock from host
    input wire spi_mosi, // spi data from host
    output wire spi_miso, // spi data to host
    output wire spi_miso_oe_n, // miso output enable, low while driving
    output wire irq_n, // interrupt pin, active low
    input wire rx_ready_set, // pulse: new payload received
    input wire tx_done_set, // pulse: packet sent
    input wire retry_limit_set, // pulse: retries exhausted
    input wire [2:0] rx_pipe_number, // pipe of the payload at fifo head
    input wire tx_fifo_full, // transmit fifo full
    output wire crc_enable, // effective crc enable
    output wire checksum_length_select, // 0 one byte, 1 two bytes
    output wire power_on_select, // 1 powered up
    output wire primary_receiver_select, // 1 primary receiver
    output wire [5:0] auto_ack_pipe_enables, // per-pipe auto ack
    output wire [5:0] receive_pipe_enables, // per-pipe receive enable
    output wire [1:0] address_length_code, // address width code
    output reg [4:0] address_byte_mask, // bytes of stored address in use, lsb first
    output wire [3:0] retransmit_delay_code, // retransmit delay code
    output wire [3:0] retransmit_count, // retransmit count limit
    output reg [19:0] retransmit_delay_cycles // clk cycles of retransmit wait
);

// ----------------------------------------------------------------
// transaction states
// ----------------------------------------------------------------
localparam [3:0] ST_CMD = 4'h1;
localparam [3:0] ST_READ = 4'h2;
localparam [3:0] ST_WRITE = 4'h4;
localparam [3:0] ST_IGNORE = 4'h8;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [1:0] csn_sync_ff;
reg [1:0] sck_sync_ff;
reg [1:0] mosi_sync_ff;
reg csn_dly_ff;
reg sck_dly_ff;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        csn_sync_ff <= 2'h3;
        sck_sync_ff <= 2'h0;
        mosi_sync_ff <= 2'h0;
        csn_dly_ff <= 1'b1;
        sck_dly_ff <= 1'b0;
    end else begin
        csn_sync_ff <= {csn_sync_ff[0], spi_csn_n};
        sck_sync_ff <= {sck_sync_ff[0], spi_sck};
        mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
        csn_dly_ff <= csn_sync_ff[1];
        sck_dly_ff <= sck_sync_ff[1];
    end
end

wire csn_n_s = csn_sync_ff[1];
wire frame_start = csn_dly_ff & ~csn_n_s;
wire sck_rise = ~csn_n_s & sck_sync_ff[1] & ~sck_dly_ff;
wire sck_fall = ~csn_n_s & ~sck_sync_ff[1] & sck_dly_ff;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [6:0] config_ff;
reg [5:0] auto_ack_ff;
reg [5:0] rx_pipes_ff;
reg [1:0] addr_width_ff;
reg [3:0] retr_delay_ff;
reg [3:0] retr_count_ff;
reg rx_ready_ff;
reg tx_done_ff;
reg retry_limit_ff;
reg irq_n_ff;

// ----------------------------------------------------------------
// spi shifter state
// ----------------------------------------------------------------
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [2:0] bit_cnt_ff;
reg [7:0] rx_sh_ff;
reg [7:0] tx_sh_ff;
reg [4:0] addr_ff;
reg reload_ff;

wire [7:0] rx_byte = {rx_sh_ff[6:0], mosi_sync_ff[1]};
wire byte_done = sck_rise & (bit_cnt_ff == 3'h7);

wire crc_forced = config_ff[`RCRB_BIT_CRC_EN] | (|auto_ack_ff); // R5
wire [7:0] status_byte = {1'b0, rx_ready_ff, tx_done_ff, retry_limit_ff,
                          rx_pipe_number, tx_fifo_full};

// read mux: only defined fields appear, all else zero
reg [7:0] rd_data;
always @* begin
    rd_data = 8'h00; // R1
    case (addr_ff)
        `RCRB_OFS_CONFIG: rd_data = {1'b0, config_ff[6:4], crc_forced, config_ff[2:0]};
        `RCRB_OFS_AUTO_ACK: rd_data = {2'h0, auto_ack_ff}; // R1
        `RCRB_OFS_RX_PIPES: rd_data = {2'h0, rx_pipes_ff}; // R1
        `RCRB_OFS_ADDR_WIDTH: rd_data = {6'h00, addr_width_ff}; // R1
        `RCRB_OFS_RETRANSMIT: rd_data = {retr_delay_ff, retr_count_ff};
        `RCRB_OFS_STATUS: rd_data = status_byte;
        default: rd_data = 8'h00; // R1
    endcase
end

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
// 000aaaaa reads, 001aaaaa writes, anything else only answers zeros
always @* begin
    nxt_state = state_ff;
    if (byte_done) begin
        case (state_ff)
            ST_CMD: begin
                if (rx_byte[7:5] == `RCRB_CMD_READ)
                    nxt_state = ST_READ;
                else if (rx_byte[7:5] == `RCRB_CMD_WRITE)
                    nxt_state = ST_WRITE;
                else
                    nxt_state = ST_IGNORE;
            end
            ST_READ: nxt_state = ST_IGNORE;
            ST_WRITE: nxt_state = ST_IGNORE;
            ST_IGNORE: nxt_state = ST_IGNORE;
            default: nxt_state = ST_IGNORE;
        endcase
    end
end

wire wr_commit = byte_done & (state_ff == ST_WRITE);

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        state_ff <= ST_CMD;
        bit_cnt_ff <= 3'h0;
        rx_sh_ff <= 8'h00;
        tx_sh_ff <= 8'h00;
        addr_ff <= 5'h00;
        reload_ff <= 1'b0;
    end else if (csn_n_s) begin
        // a cut frame drops its partial byte; miso idles low
        state_ff <= ST_CMD;
        bit_cnt_ff <= 3'h0;
        tx_sh_ff <= 8'h00;
        reload_ff <= 1'b0;
    end else begin
        if (frame_start) begin
            // status goes out while the command byte comes in
            tx_sh_ff <= status_byte;
        end else if (sck_fall) begin
            if (reload_ff)
                tx_sh_ff <= (state_ff == ST_READ) ? rd_data : 8'h00;
            else
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            reload_ff <= 1'b0;
        end
        if (sck_rise) begin
            rx_sh_ff <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (byte_done) begin
            reload_ff <= 1'b1;
            if (state_ff == ST_CMD)
                addr_ff <= rx_byte[4:0];
        end
        state_ff <= nxt_state;
    end
end

// ----------------------------------------------------------------
// register writes and event flags
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        config_ff <= `RCRB_RST_CONFIG; // R19
        auto_ack_ff <= `RCRB_RST_AUTO_ACK; // R9
        rx_pipes_ff <= `RCRB_RST_RX_PIPES; // R11
        addr_width_ff <= `RCRB_RST_ADDR_WIDTH; // R12
        retr_delay_ff <= `RCRB_RST_RETR_DELAY; // R14
        retr_count_ff <= `RCRB_RST_RETR_COUNT;
    end else if (wr_commit) begin
        // reserved bits are simply not stored, so they cannot read back
        case (addr_ff)
            `RCRB_OFS_CONFIG: config_ff <= rx_byte[6:0]; // R2 R3 R4 R6 R7 R8
            `RCRB_OFS_AUTO_ACK: auto_ack_ff <= rx_byte[5:0]; // R9
            `RCRB_OFS_RX_PIPES: rx_pipes_ff <= rx_byte[5:0]; // R11
            `RCRB_OFS_ADDR_WIDTH: begin
                // illegal code 00 is dropped, keeping a usable width
                if (rx_byte[1:0] != 2'h0)
                    addr_width_ff <= rx_byte[1:0]; // R12
            end
            `RCRB_OFS_RETRANSMIT: begin
                retr_delay_ff <= rx_byte[7:4]; // R14
                retr_count_ff <= rx_byte[3:0];
            end
            default: ;
        endcase
    end
end

wire clr_write = wr_commit & (addr_ff == `RCRB_OFS_STATUS);

// set wins over a simultaneous clear so no event is lost
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rx_ready_ff <= 1'b0;
        tx_done_ff <= 1'b0;
        retry_limit_ff <= 1'b0;
    end else begin
        rx_ready_ff <= rx_ready_set |
            (rx_ready_ff & ~(clr_write & rx_byte[`RCRB_BIT_RX_READY])); // R17
        tx_done_ff <= tx_done_set |
            (tx_done_ff & ~(clr_write & rx_byte[`RCRB_BIT_TX_DONE])); // R17
        retry_limit_ff <= retry_limit_set |
            (retry_limit_ff & ~(clr_write & rx_byte[`RCRB_BIT_RETRY_LIMIT])); // R17
    end
end

// ----------------------------------------------------------------
// interrupt pin
// ----------------------------------------------------------------
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        irq_n_ff <= 1'b1;
    end else begin
        irq_n_ff <= ~((rx_ready_ff & ~config_ff[`RCRB_BIT_MASK_RX]) | // R2 R17
                      (tx_done_ff & ~config_ff[`RCRB_BIT_MASK_TX]) | // R3
                      (retry_limit_ff & ~config_ff[`RCRB_BIT_MASK_RETRY])); // R4
    end
end

// ----------------------------------------------------------------
// derived settings
// ----------------------------------------------------------------
always @* begin
    case (addr_width_ff)
        2'h1: address_byte_mask = 5'h07; // R13
        2'h2: address_byte_mask = 5'h0F; // R13
        default: address_byte_mask = 5'h1F; // R13
    endcase
end

// wait is (code + 1) steps of 250 us, measured end to start of transmission
// sixteen full steps still fit the 20-bit count, so no overflow guard
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        retransmit_delay_cycles <= 20'h00000;
    end else begin
        retransmit_delay_cycles <= RETR_STEP_CYCLES[19:0] *
            ({16'h0000, retr_delay_ff} + 20'h00001); // R14 R16
    end
end

// only meaningful while spi_miso_oe_n is low
assign spi_miso = tx_sh_ff[7];
assign spi_miso_oe_n = csn_n_s;
assign irq_n = irq_n_ff;
assign crc_enable = crc_forced; // R5
assign checksum_length_select = config_ff[`RCRB_BIT_CRC_LEN]; // R6
assign power_on_select = config_ff[`RCRB_BIT_PWR]; // R7
assign primary_receiver_select = config_ff[`RCRB_BIT_PRIMARY_RECEIVER_SELECT]; // R8
assign auto_ack_pipe_enables = auto_ack_ff;
assign receive_pipe_enables = rx_pipes_ff;
assign address_length_code = addr_width_ff;
assign retransmit_delay_code = retr_delay_ff;
assign retransmit_count = retr_count_ff;

endmodule // rcrb_radio_config_register_bank

//--- testbench/rcrb_monitor.sv
// port-level assertions for the config register bank
`timescale 1ns/1ps
module rcrb_monitor #(
    parameter RETR_STEP_CYCLES = 10
) (
    input wire clk, // clock
    input wire nrst, // reset
    input wire spi_csn_n, // select
    input wire spi_miso_oe_n, // miso enable
    input wire irq_n, // interrupt
    input wire rx_ready_set, // event
    input wire tx_done_set, // event
    input wire retry_limit_set, // event
    input wire crc_enable, // crc on
    input wire checksum_length_select, // crc length
    input wire power_on_select, // power
    input wire primary_receiver_select, // role
    input wire [5:0] auto_ack_pipe_enables, // auto ack
    input wire [5:0] receive_pipe_enables, // rx pipes
    input wire [1:0] address_length_code, // width
    input wire [4:0] address_byte_mask, // bytes used
    input wire [3:0] retransmit_delay_code, // delay code
    input wire [19:0] retransmit_delay_cycles // delay count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire [20:0] cfg = {checksum_length_select, power_on_select, primary_receiver_select,
        auto_ack_pipe_enables, receive_pipe_enables, address_length_code, retransmit_delay_code};
    AST_CRC_FORCED: assert property (|auto_ack_pipe_enables |-> crc_enable)
        else $error("crc enable low with auto ack on");
    AST_WIDTH_LEGAL: assert property (address_length_code != 2'h0)
        else $error("illegal address width code");
    // the 5 bit wrap turns code 3 into 5'h1F
    AST_ADDR_BYTES: assert property (address_byte_mask == (5'h04 << address_length_code) - 5'h01)
        else $error("address byte mask wrong");
    AST_DELAY_CYCLES: assert property ($past(nrst) |->
        retransmit_delay_cycles == RETR_STEP_CYCLES * ($past(retransmit_delay_code) + 1))
        else $error("retransmit delay count wrong");
    // an unmask written inside a frame may also expose a pending flag
    AST_IRQ_CAUSE: assert property ($fell(irq_n) |->
        $past(rx_ready_set | tx_done_set | retry_limit_set, 2) || !$past(spi_csn_n, 2))
        else $error("irq asserted without event");
    AST_IRQ_CLEAR_IN_FRAME: assert property ($rose(irq_n) |-> !spi_csn_n)
        else $error("irq released outside a frame");
    AST_RESET_VALUES: assert property ($rose(nrst) |-> crc_enable && cfg == 21'h03F0F0)
        else $error("reset values wrong");
    // two synchroniser stages between the select pin and the miso enable
    AST_OE_FOLLOWS_SELECT: assert property (spi_miso_oe_n == $past(spi_csn_n, 2))
        else $error("miso enable does not follow select");
    AST_CFG_IN_FRAME: assert property (!$stable(cfg) |-> !spi_csn_n)
        else $error("config changed outside a frame");
endmodule // rcrb_monitor

bind rcrb_radio_config_register_bank rcrb_monitor #(.RETR_STEP_CYCLES(RETR_STEP_CYCLES)) i_mon (
    .clk(clk),
    .nrst(nrst),
    .spi_csn_n(spi_csn_n),
    .spi_miso_oe_n(spi_miso_oe_n),
    .irq_n(irq_n),
    .rx_ready_set(rx_ready_set),
    .tx_done_set(tx_done_set),
    .retry_limit_set(retry_limit_set),
    .crc_enable(crc_enable),
    .checksum_length_select(checksum_length_select),
    .power_on_select(power_on_select),
    .primary_receiver_select(primary_receiver_select),
    .auto_ack_pipe_enables(auto_ack_pipe_enables),
    .receive_pipe_enables(receive_pipe_enables),
    .address_length_code(address_length_code),
    .address_byte_mask(address_byte_mask),
    .retransmit_delay_code(retransmit_delay_code),
    .retransmit_delay_cycles(retransmit_delay_cycles)
);

//--- testbench/rcrb_host_model.sv
// host spi master model, mode 0, msb first
`timescale 1ns/1ps
module rcrb_host_model (
    input wire clk, // paces the spi edges
    output reg spi_csn_n = 1'b1, // select, idle high
    output reg spi_sck = 1'b0, // still low outside frames
    output reg spi_mosi = 1'b0, // data to device
    input wire spi_miso // data from device
);
    // 40 ns half period keeps sck above the 2ff sampling limit
    task half;
        begin
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    task automatic xfer(input [7:0] cmd, input [7:0] dat, output [7:0] st, output [7:0] rd);
        reg [15:0] got;
        reg [15:0] word;
        integer i;
        begin
            word = {cmd, dat};
            @(posedge clk);
            #1 spi_csn_n = 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                spi_mosi = word[i];
                half();
                spi_sck = 1'b1;
                got[i] = spi_miso;
                half();
                spi_sck = 1'b0;
            end
            half();
            spi_csn_n = 1'b1;
            // undriven line: no pull, so show the inverse
            spi_mosi = ~spi_mosi;
            repeat (12) @(posedge clk);
            st = got[15:8];
            rd = got[7:0];
        end
    endtask
endmodule // rcrb_host_model

//--- testbench/tb.sv
// self-checking bench for the config register bank
`timescale 1ns/1ps
module tb;
    localparam STEP = 10;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg rx_ready_set = 1'b0;
    reg tx_done_set = 1'b0;
    reg retry_limit_set = 1'b0;
    reg [2:0] rx_pipe_number = 3'h5;
    reg tx_fifo_full = 1'b1;
    wire spi_csn_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe_n, irq_n, crc_enable;
    wire checksum_length_select, power_on_select, primary_receiver_select;
    wire [5:0] auto_ack_pipe_enables, receive_pipe_enables;
    wire [1:0] address_length_code;
    wire [4:0] address_byte_mask;
    wire [3:0] retransmit_delay_code, retransmit_count;
    wire [19:0] retransmit_delay_cycles;
    integer errors = 0;
    integer checked = 0;
    integer i;
    reg [7:0] st, rd;
    reg [2:0] ev;
    rcrb_radio_config_register_bank #(.RETR_STEP_CYCLES(STEP)) i_rcrb_radio_config_register_bank (
        .clk(clk),
        .nrst(nrst),
        .spi_csn_n(spi_csn_n),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n),
        .irq_n(irq_n),
        .rx_ready_set(rx_ready_set),
        .tx_done_set(tx_done_set),
        .retry_limit_set(retry_limit_set),
        .rx_pipe_number(rx_pipe_number),
        .tx_fifo_full(tx_fifo_full),
        .crc_enable(crc_enable),
        .checksum_length_select(checksum_length_select),
        .power_on_select(power_on_select),
        .primary_receiver_select(primary_receiver_select),
        .auto_ack_pipe_enables(auto_ack_pipe_enables),
        .receive_pipe_enables(receive_pipe_enables),
        .address_length_code(address_length_code),
        .address_byte_mask(address_byte_mask),
        .retransmit_delay_code(retransmit_delay_code),
        .retransmit_count(retransmit_count),
        .retransmit_delay_cycles(retransmit_delay_cycles)
    );
    rcrb_host_model host (
        .clk(clk),
        .spi_csn_n(spi_csn_n),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso)
    );
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        host.xfer({3'h1, a}, d, st, rd);
    endtask
    task rdc(input [4:0] a, input [7:0] e);
        begin
            host.xfer({3'h0, a}, 8'h00, st, rd);
            chk("readback", rd, e);
        end
    endtask
    task pulse(input [2:0] v);
        begin
            @(posedge clk);
            #1 {rx_ready_set, tx_done_set, retry_limit_set} = v;
            @(posedge clk);
            #1 {rx_ready_set, tx_done_set, retry_limit_set} = 3'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    task report_and_stop;
        begin
            if (errors == 0 && checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        errors = errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        rdc(5'h00, 8'h08);
        chk("status", st, 8'h0B);
        rdc(5'h01, 8'h3F);
        rdc(5'h02, 8'h03);
        rdc(5'h03, 8'h03);
        rdc(5'h04, 8'h03);
        chk("retr count", retransmit_count, 4'h3);
        wr(5'h05, 8'h5A);
        rdc(5'h05, 8'h00);
        wr(5'h00, 8'h76);
        rdc(5'h00, 8'h7E);
        chk("crc pwr rol", {checksum_length_select, power_on_select, primary_receiver_select}, 3'h6);
        wr(5'h01, 8'h00);
        rdc(5'h00, 8'h76);
        chk("crc", crc_enable, 1'b0);
        wr(5'h00, 8'h71);
        chk("role", {power_on_select, primary_receiver_select}, 2'h1);
        for (i = 0; i < 3; i = i + 1) begin
            ev = 3'h4 >> i;
            pulse(ev);
            chk("irq masked", irq_n, 1'b1);
            wr(5'h07, {1'b0, ev, 4'h0});
            wr(5'h00, 8'h71 & ~{1'b0, ev, 4'h0});
            pulse(ev);
            chk("irq", irq_n, 1'b0);
            rdc(5'h07, {1'b0, ev, 4'hB});
            wr(5'h07, {1'b0, ev, 4'h0});
            chk("irq clear", irq_n, 1'b1);
            wr(5'h00, 8'h71);
        end
        for (i = 1; i < 4; i = i + 1) begin
            wr(5'h03, i[7:0]);
            chk("width mask", address_byte_mask, (32'h1 << (i + 2)) - 1);
        end
        wr(5'h03, 8'h00);
        rdc(5'h03, 8'h03);
        // codes 0, 1 and 15
        for (i = 0; i < 16; i = i * 14 + 1) begin
            wr(5'h04, {i[3:0], 4'h3});
            chk("delay", retransmit_delay_cycles, STEP * (i + 1));
        end
        wr(5'h02, 8'h3C);
        chk("rx pipes", receive_pipe_enables, 6'h3C);
        wr(5'h01, 8'h15);
        rdc(5'h01, 8'h15);
        chk("crc forced", crc_enable, 1'b1);
        // second reset in mid-run: written settings must fall back
        #1 nrst = 1'b0;
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        rdc(5'h01, 8'h3F);
        rdc(5'h02, 8'h03);
        report_and_stop;
    end
endmodule // tb
